// [dv/mac_model.sv]
// Behavioural MAC facing the PHY end: sends nibbles, records received
// nibbles and masters management frames. The bench resolves the line.
`timescale 1ns/10ps
module mac_model (
  input wire logic clk_i,
  input wire logic tx_nibble_clock_i,
  output logic [3:0] tx_nibble_o,
  output logic tx_nibble_enable_o,
  output logic tx_error_out_o,
  input wire logic collision_in_i,
  input wire logic rx_nibble_clock_i,
  input wire logic [3:0] rx_nibble_i,
  input wire logic rx_nibble_valid_i,
  input wire logic rx_error_in_i,
  output logic mgmt_clock_out_o,
  output logic mgmt_dout_o,
  output logic mgmt_drive_o,
  input wire logic mgmt_line_i
);
  logic [1:0] col_sync = 2'h0;
  logic [4:0] rxq[$];

  // Idle levels; the management clock stands still between frames.
  initial begin
    tx_nibble_o = 4'h0;
    tx_nibble_enable_o = 1'b0;
    mgmt_clock_out_o = 1'b0;
    mgmt_dout_o = 1'b1;
    mgmt_drive_o = 1'b0;
  end
  assign tx_error_out_o = 1'b0;

  // Collision is asynchronous, so two flops settle it before use.
  always @(posedge tx_nibble_clock_i)
    col_sync <= {col_sync[0], collision_in_i};

  // Receive nibbles count only while valid is high.
  always @(posedge rx_nibble_clock_i)
    if (rx_nibble_valid_i === 1'b1) rxq.push_back({rx_error_in_i, rx_nibble_i});

  // A flow stop holds a new packet back; one under way is not cut.
  task automatic send(input int n, input logic [3:0] first);
    int i;
    while (col_sync[1] !== 1'b0) @(posedge tx_nibble_clock_i);
    // Pins move 6 ns after the rise, on a system clock falling edge, so
    // they never race the synchroniser's sampling edge.
    for (i = 0; i < n; i++) begin
      @(posedge tx_nibble_clock_i);
      #6;
      tx_nibble_enable_o = 1'b1;
      tx_nibble_o = first + 4'(i);
    end
    @(posedge tx_nibble_clock_i);
    #6;
    tx_nibble_enable_o = 1'b0;
    tx_nibble_o = ~tx_nibble_o;
  endtask

  // Short clock burst so the management side leaves reset.
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge clk_i) mgmt_clock_out_o = 1'b1;
      @(negedge clk_i) mgmt_clock_out_o = 1'b0;
    end
  endtask

  // One management frame; the line is let go for read turnaround and data.
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa,
      input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    int i;
    f = {32'hFFFFFFFF, 2'h1, op, pa, ra, 2'h2, wd};
    for (i = 63; i >= 0; i--) begin
      mgmt_drive_o = !(op == 2'h2 && i < 18);
      mgmt_dout_o = f[i];
      repeat (4) @(negedge clk_i);
      if (i < 16) rd[i] = mgmt_line_i;
      mgmt_clock_out_o = 1'b1;
      repeat (4) @(negedge clk_i);
      mgmt_clock_out_o = 1'b0;
    end
    mgmt_drive_o = 1'b0;
    // Lets a clock edge pass so a following frame never re-drives the
    // line in the same time step.
    @(negedge clk_i);
  endtask
endmodule // mac_model

// [dv/mii_phy_end_bench.sv]
// Self-checking bench for the PHY end against a behavioural MAC.
// Assumes a pull-up on the management line.
`timescale 1ns/10ps
module mii_phy_end_bench;
  import mii_phy_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, fast = 1'b1, fdx = 1'b0;
  logic stop = 1'b0, force_col = 1'b0, rx_last = 1'b0;
  logic rx_err = 1'b0, rx_valid = 1'b0;
  logic [3:0] rx_data = 4'h0;
  logic tx_clk, tx_en, tx_err, col, crs, rx_clk, rx_dv, rx_er, mclk;
  logic mdo, moe_n, mac_do, mac_drv, line, rx_ready, strobe, active;
  logic err_seen, reg_wr;
  logic [3:0] tx_nib, rx_nib, tx_data;
  logic [4:0] reg_addr, wr_addr;
  logic [15:0] reg_data, wr_data;
  int failures = 0, n_tests = 0, wr_count = 0, clash = 0, stray = 0;
  logic refused = 1'b0;
  logic [3:0] txq[$];

  assign line = (moe_n ? 1'b1 : mdo) & (mac_drv ? mac_do : 1'b1);
  always #2 clk = ~clk;

  mii_phy_end DUT (.clk_i(clk), .resetn_i(resetn), .speed_fast_i(fast),
    .full_duplex_i(fdx), .flow_stop_i(stop), .collision_force_i(force_col),
    .tx_nibble_clock_o(tx_clk), .tx_nibble_i(tx_nib),
    .tx_nibble_enable_i(tx_en), .tx_error_out_i(tx_err),
    .collision_in_o(col), .carrier_sense_in_o(crs),
    .rx_nibble_clock_o(rx_clk), .rx_nibble_o(rx_nib),
    .rx_nibble_valid_o(rx_dv), .rx_error_in_o(rx_er),
    .mgmt_clock_out_i(mclk), .mgmt_data_i(line), .mgmt_data_o(mdo),
    .mgmt_data_oe_n_o(moe_n), .rx_data_i(rx_data), .rx_last_i(rx_last),
    .rx_err_i(rx_err), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready),
    .tx_data_o(tx_data), .tx_strobe_o(strobe), .tx_frame_active_o(active),
    .tx_error_seen_o(err_seen), .reg_write_o(reg_wr),
    .reg_write_addr_o(reg_addr), .reg_write_data_o(reg_data));

  mac_model mac (.clk_i(clk), .tx_nibble_clock_i(tx_clk),
    .tx_nibble_o(tx_nib), .tx_nibble_enable_o(tx_en),
    .tx_error_out_o(tx_err), .collision_in_i(col),
    .rx_nibble_clock_i(rx_clk), .rx_nibble_i(rx_nib),
    .rx_nibble_valid_i(rx_dv), .rx_error_in_i(rx_er),
    .mgmt_clock_out_o(mclk), .mgmt_dout_o(mac_do),
    .mgmt_drive_o(mac_drv), .mgmt_line_i(line));

  // Mid-cycle monitor, so registered outputs are settled when read.
  always @(negedge clk) begin
    if (strobe === 1'b1) txq.push_back(tx_data);
    if (reg_wr === 1'b1) begin
      wr_count++;
      wr_addr = reg_addr;
      wr_data = reg_data;
    end
    if (mac_drv && moe_n === 1'b0) clash++;
    if (rx_er === 1'b1 && rx_dv !== 1'b1) stray++;
  end

  //////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Counts system cycles up to the next rising edge of a nibble clock.
  task automatic gap(input logic sel, output int n);
    logic prev, cur;
    prev = 1'b1;
    for (n = 1; n < 400; n++) begin
      @(negedge clk);
      cur = sel ? rx_clk : tx_clk;
      if (prev === 1'b0 && cur === 1'b1) break;
      prev = cur;
    end
  endtask

  // The first gap after a speed change may be odd, so two transmit gaps and one receive gap are skipped.
  task automatic t_clocks(input logic [15:0] exp);
    int n;
    gap(0, n);
    gap(0, n);
    gap(0, n);
    chk("tx clock period", exp, 16'(n));
    gap(1, n);
    gap(1, n);
    chk("rx clock period", exp, 16'(n));
    $display("test clocks done");
  endtask

  // Half duplex transmit: nibbles arrive in order, carrier follows.
  task automatic t_tx;
    int i;
    txq.delete();
    fork
      mac.send(6, 4'hA);
      begin
        repeat (45) @(negedge clk);
        chk("carrier in frame", 1, crs);
        chk("no collision", 0, col);
      end
    join
    repeat (30) @(negedge clk);
    chk("tx count", 6, 16'(txq.size()));
    for (i = 0; i < txq.size(); i++) chk("tx nibble", 16'(4'hA + i), txq[i]);
    chk("frame ended", 0, active);
    chk("tx error seen", 0, err_seen);
    $display("test transmit done");
  endtask

  // Hands one word to the FIFO, holding it until ready takes it.
  task automatic push(input logic [5:0] w);
    int k;
    {rx_err, rx_last, rx_data} = w;
    rx_valid = 1'b1;
    for (k = 0; k < 500 && rx_ready !== 1'b1; k++) begin
      refused = 1'b1;
      @(negedge clk);
    end
    @(negedge clk);
  endtask

  // Twelve words overfill the FIFO; one mid-frame nibble carries an error.
  task automatic t_rx;
    int i;
    logic [5:0] w;
    mac.rxq.delete();
    // A short transmit frame overlaps the receive frame to make a collision.
    fork
      begin
        for (i = 0; i < 12; i++) push({i == 5, i == 11, 4'(i + 3)});
        rx_valid = 1'b0;
      end
      mac.send(3, 4'h2);
      begin
        repeat (35) @(negedge clk);
        chk("overlap collision", 1, col);
      end
    join
    chk("carrier on receive", 1, crs);
    chk("full refusal", 1, refused);
    repeat (200) @(negedge clk);
    chk("rx count", 12, 16'(mac.rxq.size()));
    for (i = 0; i < 12; i++) begin
      w = {i == 5, i == 11, 4'(i + 3)};
      chk("rx word", {w[5], w[3:0]}, mac.rxq[i]);
    end
    chk("error without valid", 0, 16'(stray));
    // A frame left open by the user must end in one error nibble.
    push({2'b00, 4'h7});
    rx_valid = 1'b0;
    repeat (40) @(negedge clk);
    chk("underrun count", 14, 16'(mac.rxq.size()));
    chk("underrun lead", 16'h07, mac.rxq[12]);
    chk("underrun error", 1, mac.rxq[13][4]);
    $display("test receive done");
  endtask

  // Collision sources in both duplex modes.
  task automatic t_col;
    force_col = 1'b1;
    repeat (3) @(negedge clk);
    chk("forced collision", 1, col);
    force_col = 1'b0;
    fdx = 1'b1;
    stop = 1'b1;
    repeat (3) @(negedge clk);
    chk("flow stop", 1, col);
    stop = 1'b0;
    fork
      mac.send(4, 4'h1);
      begin
        repeat (40) @(negedge clk);
        chk("full duplex carrier", 0, crs);
        chk("flow released", 0, col);
      end
    join
    fdx = 1'b0;
    $display("test collision done");
  endtask

  // Writes and reads, to our address and to another one.
  task automatic t_mgmt;
    logic [15:0] rd;
    mac.xfer(OP_WRITE, LOCAL_PHY_ADDR, 5'h05, 16'hA5C3, rd);
    repeat (20) @(negedge clk);
    chk("write count", 1, 16'(wr_count));
    chk("write addr", 16'h05, 16'(wr_addr));
    chk("write data", 16'hA5C3, wr_data);
    mac.xfer(OP_WRITE, 5'h02, 5'h06, 16'h1234, rd);
    repeat (20) @(negedge clk);
    chk("foreign write", 1, 16'(wr_count));
    mac.xfer(OP_READ, LOCAL_PHY_ADDR, 5'h05, 16'h0000, rd);
    chk("read data", 16'hA5C3, rd);
    mac.xfer(OP_READ, 5'h02, 5'h05, 16'h0000, rd);
    chk("foreign read", 16'hFFFF, rd);
    chk("line clash", 0, 16'(clash));
    $display("test management done");
  endtask

  //////////////////////////////
  // Watchdog well beyond the roughly 3100 cycles the tests need.
  initial begin
    #200000;
    failures++;
    end_of_test();
  end

  // Reset with management clock edges, then the tests.
  initial begin
    mac.tick(4);
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    chk("ready after reset", 1, rx_ready);
    chk("collision after reset", 0, col);
    chk("line released", 1, moe_n);
    // The management reset needs two edges after release to pass its flops,
    // or the first preamble would be cut short.
    mac.tick(2);
    t_clocks(16'(DIV_FAST));
    t_tx();
    t_rx();
    t_col();
    t_mgmt();
    // Switch speed in the low phase so no high phase is stretched.
    @(negedge tx_clk);
    @(negedge clk);
    fast = 1'b0;
    t_clocks(16'(DIV_SLOW));
    end_of_test();
  end
endmodule // mii_phy_end_bench

// [src/mii_phy_end.sv]
// PHY-side partner of a MAC nibble interface with a management slave.
// Assumes the MAC drives the management clock and the system clock
// runs at 250 MHz; the nibble clocks are divided from it.
`timescale 1ns/10ps
module mii_phy_end (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic speed_fast_i,
  input wire logic full_duplex_i,
  input wire logic flow_stop_i,
  input wire logic collision_force_i,
  output logic tx_nibble_clock_o,
  input wire logic [mii_phy_pkg::NIBBLE_W-1:0] tx_nibble_i,
  input wire logic tx_nibble_enable_i,
  input wire logic tx_error_out_i,
  output logic collision_in_o,
  output logic carrier_sense_in_o,
  output logic rx_nibble_clock_o,
  output logic [mii_phy_pkg::NIBBLE_W-1:0] rx_nibble_o,
  output logic rx_nibble_valid_o,
  output logic rx_error_in_o,
  input wire logic mgmt_clock_out_i,
  input wire logic mgmt_data_i,
  output logic mgmt_data_o,
  output logic mgmt_data_oe_n_o,
  input wire logic [mii_phy_pkg::NIBBLE_W-1:0] rx_data_i,
  input wire logic rx_last_i,
  input wire logic rx_err_i,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  output logic [mii_phy_pkg::NIBBLE_W-1:0] tx_data_o,
  output logic tx_strobe_o,
  output logic tx_frame_active_o,
  output logic tx_error_seen_o,
  output logic reg_write_o,
  output logic [mii_phy_pkg::ADDR_W-1:0] reg_write_addr_o,
  output logic [mii_phy_pkg::REG_W-1:0] reg_write_data_o
);
  import mii_phy_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Nibble clock divider shared by both directions.
  logic [DIV_W-1:0] div_cnt;
  wire [DIV_W-1:0] div_top = speed_fast_i ? DIV_FAST : DIV_SLOW;
  wire [DIV_W-1:0] div_half = speed_fast_i ? HALF_FAST : HALF_SLOW;
  // The >= keeps a speed change mid-period from running past the top.
  wire at_rise = (div_cnt >= div_top - DIV_W'(1));
  wire at_fall = (div_cnt == div_half - DIV_W'(1));
  wire [DIV_W-1:0] next_div = at_rise ? '0 : div_cnt + DIV_W'(1);

  // Both clocks run free from reset release, high for half a period.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      div_cnt <= '0;
      tx_nibble_clock_o <= 1'b0;
      rx_nibble_clock_o <= 1'b0;
    end else begin
      div_cnt <= next_div;
      if (at_rise) begin
        tx_nibble_clock_o <= 1'b1;
        rx_nibble_clock_o <= 1'b1;
      end else if (at_fall) begin
        tx_nibble_clock_o <= 1'b0;
        rx_nibble_clock_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit pins are launched by the MAC on our clock, but the delay
  // is unknown, so they pass three flops before use.
  logic [5:0] txs1;
  logic [5:0] txs2;
  logic [5:0] txs3;
  // Sampled just before the next rising edge, the latest safe moment.
  wire tx_take = at_rise && (txs2 == txs3);

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      txs1 <= '0;
      txs2 <= '0;
      txs3 <= '0;
    end else begin
      txs1 <= {tx_error_out_i, tx_nibble_enable_i, tx_nibble_i};
      txs2 <= txs1;
      txs3 <= txs2;
    end
  end

  // A torn sample keeps the previous state and drops that nibble.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      tx_data_o <= '0;
      tx_strobe_o <= 1'b0;
      tx_frame_active_o <= 1'b0;
      tx_error_seen_o <= 1'b0;
    end else begin
      tx_strobe_o <= tx_take && txs3[4];
      if (tx_take) begin
        tx_frame_active_o <= txs3[4];
        tx_data_o <= txs3[3:0];
        tx_error_seen_o <= tx_error_seen_o | txs3[5];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Collision and carrier sense toward the MAC.
  wire both_busy = tx_frame_active_o && rx_nibble_valid_o;
  // Full duplex turns collision into a pure flow-stop request.
  wire next_col = full_duplex_i ? flow_stop_i
                                : (collision_force_i || both_busy);
  wire next_crs = !full_duplex_i
                  && (tx_frame_active_o || rx_nibble_valid_o);

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      collision_in_o <= 1'b0;
      carrier_sense_in_o <= 1'b0;
    end else begin
      collision_in_o <= next_col;
      carrier_sense_in_o <= next_crs;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive path: user words are buffered, then drained one per period.
  stream_if #(.W(RX_WORD_W)) rx_in ();
  stream_if #(.W(RX_WORD_W)) rx_out ();
  assign rx_in.data = {rx_err_i, rx_last_i, rx_data_i};
  assign rx_in.valid = rx_valid_i;
  assign rx_ready_o = rx_in.ready;
  // Changing on the falling edge gives the MAC half a period of setup.
  assign rx_out.ready = at_fall;

  stream_fifo #(.W(RX_WORD_W), .DEPTH(FIFO_DEPTH)) rx_fifo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_s(rx_in),
    .out_s(rx_out)
  );

  logic rx_in_frame;
  wire [RX_WORD_W-1:0] rx_word = rx_out.data;
  wire rx_pop = at_fall && rx_out.valid;
  wire rx_underrun = at_fall && !rx_out.valid && rx_in_frame;

  // An empty FIFO inside a frame sends one error nibble and ends it.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rx_nibble_o <= '0;
      rx_nibble_valid_o <= 1'b0;
      rx_error_in_o <= 1'b0;
      rx_in_frame <= 1'b0;
    end else if (rx_pop) begin
      rx_nibble_o <= rx_word[NIBBLE_W-1:0];
      rx_nibble_valid_o <= 1'b1;
      rx_error_in_o <= rx_word[RX_ERR_BIT];
      rx_in_frame <= !rx_word[RX_LAST_BIT];
    end else if (rx_underrun) begin
      rx_nibble_valid_o <= 1'b1;
      rx_error_in_o <= 1'b1;
      rx_in_frame <= 1'b0;
    end else if (at_fall) begin
      rx_nibble_valid_o <= 1'b0;
      rx_error_in_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Management slave, clocked by the MAC's management clock.
  logic mrst_q1;
  logic mrst_n;
  mgmt_state_t mstate;
  logic [5:0] ones;
  logic [3:0] mcnt;
  logic [1:0] op;
  logic [ADDR_W-1:0] phy;
  logic [ADDR_W-1:0] regad;
  logic [REG_W-1:0] shreg;
  logic [REG_W-1:0] regs [REG_COUNT];
  logic wr_tgl;
  logic [ADDR_W-1:0] wr_addr_x;
  logic [REG_W-1:0] wr_data_x;

  wire addr_hit = (phy == LOCAL_PHY_ADDR);
  wire read_hit = addr_hit && (op == OP_READ);
  wire write_hit = addr_hit && (op == OP_WRITE);
  wire data_end = (mstate == DATA_BITS) && (mcnt == DATA_LAST);
  wire [REG_W-1:0] write_word = {shreg[REG_W-2:0], mgmt_data_i};
  wire mem_we = mrst_n && data_end && write_hit;

  // Reset level carried over into the management domain.
  always_ff @(posedge mgmt_clock_out_i) begin
    mrst_q1 <= resetn_i;
    mrst_n <= mrst_q1;
  end

  // Register store written by management frames addressed to us.
  always_ff @(posedge mgmt_clock_out_i) begin
    if (mem_we) begin
      regs[regad] <= write_word;
    end
  end

  // The walker samples on the rising edge and launches read data on
  // the same edge, so it is valid a full period before the next one.
  always_ff @(posedge mgmt_clock_out_i) begin
    if (!mrst_n) begin
      mstate <= HUNT;
      ones <= '0;
      mcnt <= '0;
      op <= '0;
      phy <= '0;
      regad <= '0;
      shreg <= '0;
      wr_tgl <= 1'b0;
      wr_addr_x <= '0;
      wr_data_x <= '0;
      mgmt_data_o <= 1'b1;
      mgmt_data_oe_n_o <= 1'b1;
    end else begin
      mcnt <= mcnt + 4'h1;
      unique case (mstate)
        HUNT: begin
          mcnt <= '0;
          if (mgmt_data_i) begin
            ones <= (ones == PREAMBLE_ONES) ? ones : ones + 6'h01;
          end else begin
            ones <= '0;
            if (ones == PREAMBLE_ONES) mstate <= START_BIT;
          end
        end
        START_BIT: begin
          mcnt <= '0;
          mstate <= mgmt_data_i ? OPCODE : HUNT;
        end
        OPCODE: begin
          op <= {op[0], mgmt_data_i};
          if (mcnt == OP_LAST) begin
            mcnt <= '0;
            mstate <= PHY_FIELD;
          end
        end
        PHY_FIELD: begin
          phy <= {phy[ADDR_W-2:0], mgmt_data_i};
          if (mcnt == ADDR_LAST) begin
            mcnt <= '0;
            mstate <= REG_FIELD;
          end
        end
        REG_FIELD: begin
          regad <= {regad[ADDR_W-2:0], mgmt_data_i};
          if (mcnt == ADDR_LAST) begin
            mcnt <= '0;
            mstate <= TURNAROUND;
          end
        end
        TURNAROUND: begin
          if (mcnt == 4'h0) begin
            // Second turnaround bit: drive zero on a read to us.
            if (read_hit) begin
              mgmt_data_o <= 1'b0;
              mgmt_data_oe_n_o <= 1'b0;
            end
          end else begin
            mcnt <= '0;
            mstate <= DATA_BITS;
            if (read_hit) begin
              mgmt_data_o <= regs[regad][REG_W-1];
              shreg <= {regs[regad][REG_W-2:0], 1'b0};
            end
          end
        end
        DATA_BITS: begin
          if (read_hit) begin
            mgmt_data_o <= shreg[REG_W-1];
            shreg <= {shreg[REG_W-2:0], 1'b0};
          end else begin
            shreg <= write_word;
          end
          if (data_end) begin
            mstate <= HUNT;
            ones <= '0;
            mgmt_data_o <= 1'b1;
            mgmt_data_oe_n_o <= 1'b1;
            if (write_hit) begin
              wr_addr_x <= regad;
              wr_data_x <= write_word;
              wr_tgl <= ~wr_tgl;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write notices cross by toggle; address and data stay still for a
  // whole frame, far longer than the three-flop crossing.
  logic wt1;
  logic wt2;
  logic wt3;
  logic wt_seen;
  wire wr_event = (wt2 == wt3) && (wt3 != wt_seen);

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wt1 <= 1'b0;
      wt2 <= 1'b0;
      wt3 <= 1'b0;
      wt_seen <= 1'b0;
      reg_write_o <= 1'b0;
      reg_write_addr_o <= '0;
      reg_write_data_o <= '0;
    end else begin
      wt1 <= wr_tgl;
      wt2 <= wt1;
      wt3 <= wt2;
      reg_write_o <= wr_event;
      if (wr_event) begin
        wt_seen <= wt3;
        reg_write_addr_o <= wr_addr_x;
        reg_write_data_o <= wr_data_x;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks on the system clock domain.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  chk_fast_high_time: assert property (
    $rose(tx_nibble_clock_o) && speed_fast_i |->
      tx_nibble_clock_o[*5] ##1 !tx_nibble_clock_o)
    else $error("Fast transmit clock high phase is wrong.");

  chk_slow_high_time: assert property (
    $rose(rx_nibble_clock_o) && !speed_fast_i |-> ##50 $fell(rx_nibble_clock_o))
    else $error("Slow receive clock high phase is wrong.");

  chk_hd_collision: assert property (
    !full_duplex_i && both_busy |=> collision_in_o)
    else $error("Overlapping traffic gave no collision.");

  chk_flow_quiet: assert property (
    full_duplex_i && !flow_stop_i |=> !collision_in_o)
    else $error("Collision raised without flow stop.");

  chk_hd_carrier: assert property (
    !full_duplex_i && rx_nibble_valid_o |=> carrier_sense_in_o)
    else $error("Receive traffic without carrier sense.");

  chk_fd_carrier_low: assert property (
    full_duplex_i |=> !carrier_sense_in_o)
    else $error("Carrier sense raised in full duplex.");

  chk_rx_on_fall: assert property (
    $changed(rx_nibble_valid_o) || $changed(rx_nibble_o) |->
      $fell(rx_nibble_clock_o))
    else $error("Receive outputs moved off the falling edge.");

  chk_rx_err_valid: assert property (
    rx_error_in_o |-> rx_nibble_valid_o)
    else $error("Receive error without receive valid.");

  chk_rx_order: assert property (
    rx_pop |=> rx_nibble_valid_o && rx_nibble_o == $past(rx_word[3:0]))
    else $error("Receive nibble differs from buffered word.");

  cov_rx_error: cover property (rx_nibble_valid_o && rx_error_in_o);
  cov_collision: cover property (!full_duplex_i && collision_in_o);
  cov_flow_stop: cover property (full_duplex_i && collision_in_o);
  cov_reg_write: cover property (reg_write_o);

  ////////////////////////////////////////////////////////////////////////
  // Checks on the management clock domain.
  chk_line_released: assert property (
    @(posedge mgmt_clock_out_i) disable iff (!mrst_n)
    !(mstate inside {TURNAROUND, DATA_BITS}) |-> mgmt_data_oe_n_o)
    else $error("Management line driven outside read data.");

  chk_read_turn: assert property (
    @(posedge mgmt_clock_out_i) disable iff (!mrst_n)
    mstate == TURNAROUND && mcnt == 4'h0 && read_hit |=>
      !mgmt_data_oe_n_o && !mgmt_data_o ##17 mgmt_data_oe_n_o)
    else $error("Read turnaround or release timing is wrong.");

  cov_mgmt_read: cover property (
    @(posedge mgmt_clock_out_i) disable iff (!mrst_n)
    mstate == DATA_BITS && read_hit);

endmodule // mii_phy_end

// [src/mii_phy_pkg.sv]
// Constants and types shared by the PHY-side link partner and its FIFO.
// Assumes a 250 MHz system clock; every count derives from the figures here.
package mii_phy_pkg;

  // System clock and the two nibble clock periods, in ns.
  localparam int CLK_PERIOD_NS = 4;
  localparam int LINK_PERIOD_FAST_NS = 40;
  localparam int LINK_PERIOD_SLOW_NS = 400;

  // Divider counts in system clock cycles.
  localparam int DIV_W = 7;
  localparam logic [DIV_W-1:0] DIV_FAST =
    DIV_W'(LINK_PERIOD_FAST_NS / CLK_PERIOD_NS);
  localparam logic [DIV_W-1:0] DIV_SLOW =
    DIV_W'(LINK_PERIOD_SLOW_NS / CLK_PERIOD_NS);
  localparam logic [DIV_W-1:0] HALF_FAST =
    DIV_W'(LINK_PERIOD_FAST_NS / (2 * CLK_PERIOD_NS));
  localparam logic [DIV_W-1:0] HALF_SLOW =
    DIV_W'(LINK_PERIOD_SLOW_NS / (2 * CLK_PERIOD_NS));

  // Receive word layout in the FIFO: {error, last, nibble}.
  localparam int NIBBLE_W = 4;
  localparam int RX_WORD_W = NIBBLE_W + 2;
  localparam int RX_LAST_BIT = 4;
  localparam int RX_ERR_BIT = 5;
  localparam int FIFO_DEPTH = 8;

  // Management frame layout.
  localparam int ADDR_W = 5;
  localparam int REG_W = 16;
  localparam int REG_COUNT = 32;
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [3:0] OP_LAST = 4'h1;
  localparam logic [3:0] ADDR_LAST = 4'h4;
  localparam logic [3:0] DATA_LAST = 4'hF;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  // Own management address; the value is arbitrary.
  localparam logic [ADDR_W-1:0] LOCAL_PHY_ADDR = 5'h01;

  // Management frame walker states.
  typedef enum logic [6:0] {
    HUNT = 7'h01,
    START_BIT = 7'h02,
    OPCODE = 7'h04,
    PHY_FIELD = 7'h08,
    REG_FIELD = 7'h10,
    TURNAROUND = 7'h20,
    DATA_BITS = 7'h40
  } mgmt_state_t;

endpackage

// [src/stream_fifo.sv]
// Synchronous FIFO with registered ready and valid flags.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module stream_fifo #(
  parameter int W = 6,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  stream_if.snk in_s,
  stream_if.src out_s
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic in_ready;
  logic out_valid;

  ////////////////////////////////////////////////////////////////////////
  // Flags are registered so the ready seen by the source is a flop.
  wire push = in_s.valid && in_ready;
  wire pop = out_s.ready && out_valid;
  wire [PW:0] next_count = count + (PW+1)'(push) - (PW+1)'(pop);
  assign in_s.ready = in_ready;
  assign out_s.valid = out_valid;
  assign out_s.data = mem[rd_ptr];

  // Storage needs no reset; the flags guard every read.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_s.data;
    end
  end

  // Pointers wrap naturally because the depth is a power of two.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_ptr <= wr_ptr + PW'(push);
      rd_ptr <= rd_ptr + PW'(pop);
      count <= next_count;
      in_ready <= (next_count != FULL);
      out_valid <= (next_count != '0);
    end
  end

endmodule // stream_fifo

// [src/stream_if.sv]
// Valid/ready word stream between the link partner and its FIFO.
// Assumes both ends share one clock.
`timescale 1ns/10ps
interface stream_if #(parameter int W = 6);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface // stream_if
